//--- common/pdpwm_params.svh
// Purpose: register offsets, field positions and reset values for pdpwm
// Assumes: included by bare name from the design files
// Notes:   definitions only
`ifndef PDPWM_PARAMS_SVH
`define PDPWM_PARAMS_SVH
// register offsets, channel 0 then channel 1 (stride 3)
`define PDPWM_OFF_CTRL0    4'h0
`define PDPWM_OFF_DUTYL0   4'h1
`define PDPWM_OFF_DUTYH0   4'h2
`define PDPWM_CH_STRIDE    4'h3
`define PDPWM_OFF_STANDBY  4'h6
`define PDPWM_OFF_STATUS   4'h7
// control field positions
`define PDPWM_CKS_LSB      0
`define PDPWM_FMT_BIT      2
// reset values
`define PDPWM_CKS_RST      2'h0
`define PDPWM_FMT_RST      1'h0
`define PDPWM_DUTY_RST     10'h000
// read values
`define PDPWM_CTRL_RDVAL   8'hff
`define PDPWM_UNMAP_RDVAL  8'h00
// timing: periods in system clocks per clock select
`define PDPWM_PERIOD_CKS0  512
`define PDPWM_PERIOD_CKS3  4096
`endif

//--- common/pdpwm_pkg.sv
// Purpose: shared types for pdpwm
// Assumes: nothing
// Notes:   constants live in pdpwm_params.svh
package pdpwm_pkg;
  // clock select codes
  typedef enum logic [1:0] {
    PDPWM_CKS_DIV1 = 2'h0,
    PDPWM_CKS_DIV2 = 2'h1,
    PDPWM_CKS_DIV4 = 2'h2,
    PDPWM_CKS_DIV8 = 2'h3
  } pdpwm_cks_e;
  // register bus data
  typedef logic [7:0] pdpwm_byte_t;
endpackage

//--- logic/pdpwm_chan.sv
// Purpose: one pulse-division modulator channel
// Assumes: clk_i 100 MHz, inputs synchronous to clk_i
// Notes:   output high iff bit-reversed position is below the duty value; divide-by-1 compares rev[8:0] with duty_i[9:1]
`timescale 1ns/1ps
`default_nettype none
module pdpwm_chan #(
  parameter int DUTY_W = 10
) (
  // clock, reset, enable
  input  wire logic              clk_i,
  input  wire logic              rst_b_i,
  input  wire logic              ce_i,
  // configuration
  input  wire logic              standby_i,
  input  wire pdpwm_pkg::pdpwm_cks_e cks_i,
  input  wire logic              fmt_i,
  input  wire logic [DUTY_W-1:0] duty_i,
  // output
  output logic                   pwm_o,
  output logic [DUTY_W-1:0]      pos_o
);
  logic [2:0]        pre;       // prescaler for divided clocks
  logic [DUTY_W-1:0] pos;       // position within conversion period
  logic              pwm;       // registered output level
  logic [2:0]        next_pre;
  logic [DUTY_W-1:0] next_pos;
  logic              next_pwm;
  logic [DUTY_W-1:0] rev;       // bit-reversed position
  logic [2:0]        limit;     // last prescaler count
  logic              tick;      // one step of the input clock

  // bit reversal spreads high time into many short pulses
  for (genvar i = 0; i < DUTY_W; i++) begin : g_rev
    assign rev[i] = pos[DUTY_W-1-i];
  end

  // next state of prescaler, position and output
  always_comb begin
    unique case (cks_i)
      pdpwm_pkg::PDPWM_CKS_DIV1: limit = 3'h0;
      pdpwm_pkg::PDPWM_CKS_DIV2: limit = 3'h0;
      pdpwm_pkg::PDPWM_CKS_DIV4: limit = 3'h1;
      pdpwm_pkg::PDPWM_CKS_DIV8: limit = 3'h3;
    endcase
    tick     = (pre >= limit);
    next_pre = tick ? 3'h0 : pre + 3'h1;
    next_pos = pos;
    if (tick) begin
      // divide-by-1 covers two half-clock steps per clock
      next_pos = pos + ((cks_i == pdpwm_pkg::PDPWM_CKS_DIV1) ?
                 DUTY_W'(2) : DUTY_W'(1));
    end
    if (cks_i == pdpwm_pkg::PDPWM_CKS_DIV1) begin
      next_pwm = (rev[DUTY_W-2:0] < duty_i[DUTY_W-1:1]);
    end else begin
      next_pwm = (rev < duty_i);
    end
    // standby or event-counter format stops this channel
    if (standby_i || fmt_i) begin
      next_pre = 3'h0;
      next_pos = '0;
      next_pwm = 1'b0;
    end
  end

  // register state
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      pre <= 3'h0;
      pos <= '0;
      pwm <= 1'b0;
    end else if (ce_i) begin
      pre <= next_pre;
      pos <= next_pos;
      pwm <= next_pwm;
    end
  end

  assign pwm_o = pwm;
  assign pos_o = pos;

  // zero duty never drives the pin high
  property p_zero_low;
    @(posedge clk_i) disable iff (!rst_b_i)
    (duty_i == '0) && $stable(duty_i) |=> !pwm_o;
  endproperty
  a_zero_low: assert property (p_zero_low)
    else $error("pwm high with zero duty");

  // standby forces the output low and parks the position
  property p_standby;
    @(posedge clk_i) disable iff (!rst_b_i)
    standby_i && ce_i |=> !pwm_o && (pos_o == '0);
  endproperty
  a_standby: assert property (p_standby)
    else $error("channel active during standby");

  // divide-by-1 steps two positions per clock
  property p_div1_step;
    @(posedge clk_i) disable iff (!rst_b_i)
    ce_i && !standby_i && !fmt_i &&
    cks_i == pdpwm_pkg::PDPWM_CKS_DIV1 |=>
    pos_o == DUTY_W'($past(pos_o) + DUTY_W'(2));
  endproperty
  a_div1_step: assert property (p_div1_step)
    else $error("divide-by-1 step wrong");

  // divide-by-8 holds each position for four clocks
  property p_div8_hold;
    @(posedge clk_i) disable iff (!rst_b_i)
    ce_i && !standby_i && !fmt_i && $changed(pos_o) &&
    cks_i == pdpwm_pkg::PDPWM_CKS_DIV8 && $stable(cks_i) ##1
    (ce_i && !standby_i && !fmt_i &&
    cks_i == pdpwm_pkg::PDPWM_CKS_DIV8) [*2] |=>
    pos_o == $past(pos_o, 3);
  endproperty
  a_div8_hold: assert property (p_div8_hold)
    else $error("divide-by-8 position moved early");
endmodule
`default_nettype wire

//--- logic/pdpwm_top.sv
// Purpose: two-channel 10-bit pulse-division modulator with register port
// Assumes: clk_i 100 MHz, synchronous active-low reset, inputs synchronous
// Notes:   control registers read as all ones; duty registers read back
//
// Our own choices: the register addresses and strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "pdpwm_params.svh"

// Summary of operation
// - two identical 10-bit channels, own control and pin
// - clock select picks divide 1, 2, 4, 8
// - clock select bits write-only, read as one
// - upper control bits read one, ignore writes
// - bit 2 picks output format, reads one
// - pulse division spreads high time across period
// - per-channel standby stops the modulator
module pdpwm_top #(
  parameter int NUM_CH = 2,
  parameter int DUTY_W = 10
) (
  // clock, reset, enable
  input  wire logic              clk_i,
  input  wire logic              rst_b_i,
  input  wire logic              ce_i,
  // register port
  input  wire logic [3:0]        addr_i,
  input  wire logic [7:0]        wdata_i,
  input  wire logic              wr_i,
  input  wire logic              rd_i,
  output logic [7:0]             rdata_o,
  // modulator pins
  output logic [NUM_CH-1:0]      pwm_o
);
  // elaboration check: the map holds two channels of 10 bits
  if (NUM_CH != 2 || DUTY_W != 10) begin : g_bad_param
    $error("pdpwm_top supports NUM_CH=2 and DUTY_W=10 only");
  end

  // per-channel configuration state
  pdpwm_pkg::pdpwm_cks_e       cks     [NUM_CH];
  logic [NUM_CH-1:0]           fmt;            // output format select
  logic [DUTY_W-1:0]           duty    [NUM_CH];
  logic [NUM_CH-1:0]           standby;        // module standby bits
  pdpwm_pkg::pdpwm_cks_e       next_cks[NUM_CH];
  logic [NUM_CH-1:0]           next_fmt;
  logic [DUTY_W-1:0]           next_duty[NUM_CH];
  logic [NUM_CH-1:0]           next_standby;
  // read path
  pdpwm_pkg::pdpwm_byte_t      rdata;          // registered read data
  pdpwm_pkg::pdpwm_byte_t      next_rdata;
  // channel state seen by status
  logic [NUM_CH-1:0]           pwm_lvl;
  logic [DUTY_W-1:0]           pos     [NUM_CH];

  // per-channel register decode and modulator
  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    localparam logic [3:0] BASE = 4'(c * `PDPWM_CH_STRIDE);
    logic hit_ctrl;   // write to this channel's control
    logic hit_dl;     // write to duty low byte
    logic hit_dh;     // write to duty high bits

    assign hit_ctrl = wr_i && (addr_i == `PDPWM_OFF_CTRL0 + BASE);
    assign hit_dl   = wr_i && (addr_i == `PDPWM_OFF_DUTYL0 + BASE);
    assign hit_dh   = wr_i && (addr_i == `PDPWM_OFF_DUTYH0 + BASE);

    // next configuration from register writes
    always_comb begin
      next_cks[c]  = cks[c];
      next_fmt[c]  = fmt[c];
      next_duty[c] = duty[c];
      if (hit_ctrl) begin
        // bits 7..3 are dropped on purpose
        next_cks[c] = pdpwm_pkg::pdpwm_cks_e'(
                      wdata_i[`PDPWM_CKS_LSB +: 2]);
        next_fmt[c] = wdata_i[`PDPWM_FMT_BIT];
      end
      if (hit_dl) begin
        next_duty[c][7:0] = wdata_i;
      end
      if (hit_dh) begin
        next_duty[c][DUTY_W-1:8] = wdata_i[DUTY_W-9:0];
      end
    end

    // register configuration
    always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
        cks[c]  <= pdpwm_pkg::pdpwm_cks_e'(`PDPWM_CKS_RST);
        fmt[c]  <= `PDPWM_FMT_RST;
        duty[c] <= `PDPWM_DUTY_RST;
      end else if (ce_i) begin
        cks[c]  <= next_cks[c];
        fmt[c]  <= next_fmt[c];
        duty[c] <= next_duty[c];
      end
    end

    // independent modulator for this channel
    pdpwm_chan #(
      .DUTY_W (DUTY_W)
    ) u_chan (
      .clk_i     (clk_i),
      .rst_b_i   (rst_b_i),
      .ce_i      (ce_i),
      .standby_i (standby[c]),
      .cks_i     (cks[c]),
      .fmt_i     (fmt[c]),
      .duty_i    (duty[c]),
      .pwm_o     (pwm_lvl[c]),
      .pos_o     (pos[c])
    );
  end

  // next standby and read data
  always_comb begin
    next_standby = standby;
    if (wr_i && addr_i == `PDPWM_OFF_STANDBY) begin
      next_standby = wdata_i[NUM_CH-1:0];
    end
    next_rdata = rdata;
    if (rd_i) begin
      unique case (addr_i)
        // control reads all ones whatever was written
        `PDPWM_OFF_CTRL0,
        `PDPWM_OFF_CTRL0 + `PDPWM_CH_STRIDE:
          next_rdata = `PDPWM_CTRL_RDVAL;
        `PDPWM_OFF_DUTYL0:
          next_rdata = duty[0][7:0];
        `PDPWM_OFF_DUTYH0:
          next_rdata = {6'h00, duty[0][DUTY_W-1:8]};
        `PDPWM_OFF_DUTYL0 + `PDPWM_CH_STRIDE:
          next_rdata = duty[1][7:0];
        `PDPWM_OFF_DUTYH0 + `PDPWM_CH_STRIDE:
          next_rdata = {6'h00, duty[1][DUTY_W-1:8]};
        `PDPWM_OFF_STANDBY:
          next_rdata = {6'h00, standby};
        // live pin levels and period-start flags
        `PDPWM_OFF_STATUS:
          next_rdata = {4'h0, pos[1] == '0, pos[0] == '0, pwm_lvl};
        default:
          next_rdata = `PDPWM_UNMAP_RDVAL;
      endcase
    end
  end

  // register standby and read data
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      standby <= '0;
      rdata   <= 8'h00;
    end else if (ce_i) begin
      standby <= next_standby;
      rdata   <= next_rdata;
    end
  end

  assign rdata_o = rdata;
  assign pwm_o   = pwm_lvl;

  // control read returns all ones the cycle after
  property p_ctrl_ones;
    @(posedge clk_i) disable iff (!rst_b_i)
    ce_i && rd_i && addr_i == `PDPWM_OFF_CTRL0 |=> rdata_o == 8'hff;
  endproperty
  a_ctrl_ones: assert property (p_ctrl_ones)
    else $error("control read not all ones");

  // second control read also all ones after a zero write
  property p_ctrl1_ones;
    @(posedge clk_i) disable iff (!rst_b_i)
    ce_i && wr_i && addr_i == 4'h3 && wdata_i == 8'h00 ##1
    ce_i && rd_i && addr_i == 4'h3 |=> rdata_o == 8'hff;
  endproperty
  a_ctrl1_ones: assert property (p_ctrl1_ones)
    else $error("upper control bits not read as one");

  // format bit is stored though it reads as one
  property p_fmt_store;
    @(posedge clk_i) disable iff (!rst_b_i)
    ce_i && wr_i && addr_i == `PDPWM_OFF_CTRL0 |=>
    fmt[0] == $past(wdata_i[2]) && cks[0] == $past(wdata_i[1:0]);
  endproperty
  a_fmt_store: assert property (p_fmt_store)
    else $error("control write not stored");

  // duty low write reads back two cycles later
  property p_duty_rb;
    @(posedge clk_i) disable iff (!rst_b_i)
    ce_i && wr_i && addr_i == 4'h4 ##1 ce_i && rd_i && addr_i == 4'h4
    |=> rdata_o == $past(wdata_i, 2);
  endproperty
  a_duty_rb: assert property (p_duty_rb)
    else $error("channel 1 duty readback wrong");

  // standby write lands in the standby bits
  property p_stby_store;
    @(posedge clk_i) disable iff (!rst_b_i)
    ce_i && wr_i && addr_i == `PDPWM_OFF_STANDBY |=>
    standby == $past(wdata_i[NUM_CH-1:0]);
  endproperty
  a_stby_store: assert property (p_stby_store)
    else $error("standby write not stored");

  // event-counter format holds channel 0 low
  property p_fmt1_low;
    @(posedge clk_i) disable iff (!rst_b_i)
    ce_i && fmt[0] |=> !pwm_o[0];
  endproperty
  a_fmt1_low: assert property (p_fmt1_low)
    else $error("channel 0 active in event-counter format");

  // channel 1 clock select moves only on its control write
  property p_cks_hold;
    @(posedge clk_i) disable iff (!rst_b_i)
    !(ce_i && wr_i && addr_i == `PDPWM_OFF_CTRL0 + `PDPWM_CH_STRIDE)
    |=> $stable(cks[1]);
  endproperty
  a_cks_hold: assert property (p_cks_hold)
    else $error("channel 1 clock select changed unwritten");

  // duty values move only on a register write
  property p_duty_hold;
    @(posedge clk_i) disable iff (!rst_b_i)
    !(ce_i && wr_i) |=> $stable(duty[0]) && $stable(duty[1]);
  endproperty
  a_duty_hold: assert property (p_duty_hold)
    else $error("duty changed without a write");
endmodule
`default_nettype wire

//--- verif/pdpwm_filter.sv
// Purpose: low-pass filter stand-in that integrates one modulator pin
// Assumes: pin sampled on the rising edge of clk_i, synchronous clear
// Notes:   reports high clocks and the widest high pulse since clear
`timescale 1ns/1ps
`default_nettype none
module pdpwm_filter (
  // clock and clear
  input  wire logic   clk_i,
  input  wire logic   clr_b_i,
  // pin seen by the filter
  input  wire logic   pin_i,
  // integrated results
  output logic [12:0] high_cnt_o,
  output logic [12:0] max_run_o
);
  logic [12:0] run; // length of the current high pulse
  // integrate high time and track the widest pulse (ripple measure)
  always_ff @(posedge clk_i) begin
    if (!clr_b_i) begin
      high_cnt_o <= 13'h0000;
      max_run_o  <= 13'h0000;
      run        <= 13'h0000;
    end else begin
      high_cnt_o <= high_cnt_o + 13'(pin_i);
      run        <= pin_i ? run + 13'h0001 : 13'h0000;
      if (pin_i && (run + 13'h0001 > max_run_o)) begin
        max_run_o <= run + 13'h0001;
      end
    end
  end
endmodule
`default_nettype wire

//--- verif/tb_top.sv
// Purpose: self-checking bench for the two-channel modulator
// Assumes: register port with read data one cycle after the read strobe
// Notes:   pins judged through two filter models, one per channel
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin \
  miscompares++; $display("unexpected %s exp %h got %h", nm, e, g); end end
module tb_top;
  logic        clk_i = 1'b0;  // system clock
  logic        rst_b_i = 1'b0; // synchronous reset
  logic        ce_i = 1'b1;    // clock enable
  logic [3:0]  addr = 4'h0;    // register address
  logic [7:0]  wdata = 8'h00;  // write data
  logic        wr_s = 1'b0;    // write strobe
  logic        rd_s = 1'b0;    // read strobe
  logic [7:0]  rdata;          // read data
  logic [1:0]  pwm;            // modulator pins
  logic        clr_b = 1'b0;   // filter clear
  logic [12:0] cnt0, cnt1, run0, run1; // filter results
  int          miscompares = 0;
  int          comparisons = 0;
  // design and one filter per pin
  pdpwm_top dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(ce_i),
    .addr_i(addr), .wdata_i(wdata), .wr_i(wr_s), .rd_i(rd_s),
    .rdata_o(rdata), .pwm_o(pwm));
  pdpwm_filter flt0 (.clk_i(clk_i), .clr_b_i(clr_b), .pin_i(pwm[0]),
    .high_cnt_o(cnt0), .max_run_o(run0));
  pdpwm_filter flt1 (.clk_i(clk_i), .clr_b_i(clr_b), .pin_i(pwm[1]),
    .high_cnt_o(cnt1), .max_run_o(run1));
  // 100 MHz clock
  always #5 clk_i = ~clk_i;
  // one-cycle register write
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr  <= a;
    wdata <= d;
    wr_s  <= 1'b1;
    @(posedge clk_i);
    wr_s  <= 1'b0;
  endtask
  // one-cycle register read, data taken in the following cycle
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_i);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk_i);
    rd_s <= 1'b0;
    #1 d = rdata;
  endtask
  // write then read one place back to back, read data in the cycle after
  task automatic wr_rd(input logic [3:0] a, input logic [7:0] d,
                       input logic [7:0] e);
    @(posedge clk_i);
    addr  <= a;
    wdata <= d;
    wr_s  <= 1'b1;
    @(posedge clk_i);
    wr_s  <= 1'b0;
    rd_s  <= 1'b1;
    @(posedge clk_i);
    rd_s  <= 1'b0;
    #1;
    `CHK("rdata", e, rdata)
  endtask
  // read and compare a whole byte
  task automatic chk_rd(input logic [3:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    `CHK("rdata", e, d)
  endtask
  // integrate both pins over p clocks and compare
  task automatic meas(input logic [12:0] p, e0, e1, r0, r1);
    @(posedge clk_i);
    clr_b <= 1'b0;
    @(posedge clk_i);
    clr_b <= 1'b1;
    repeat (p) @(posedge clk_i);
    #1;
    `CHK("high0", e0, cnt0)
    `CHK("high1", e1, cnt1)
    `CHK("run0", r0, run0)
    `CHK("run1", r1, run1)
  endtask
  // reset values, read-as-one control, unmapped place
  task automatic t_reset;
    chk_rd(4'h0, 8'hff);
    chk_rd(4'h3, 8'hff);
    wr_rd(4'h3, 8'h00, 8'hff);
    chk_rd(4'h1, 8'h00);
    chk_rd(4'h6, 8'h00);
    wr(4'h9, 8'hff);
    chk_rd(4'h9, 8'h00);
  endtask
  // every clock select: period, high time and pulse width
  task automatic t_periods;
    int p;
    wr(4'h2, 8'h02);
    wr(4'h5, 8'h01);
    for (int s = 0; s < 4; s++) begin
      p = 512 << s;
      if (s != 0) begin
        wr(4'h0, 8'hf8 | 8'(s));
        wr(4'h3, 8'(s));
      end
      repeat (p + 16) @(posedge clk_i);
      meas(13'(p), 13'(p / 2), 13'(p / 4), (s == 0) ? 13'h0001 :
        13'(1 << (s - 1)), (s == 0) ? 13'h0001 : 13'(1 << (s - 1)));
      chk_rd(4'h0, 8'hff);
    end
  endtask
  // standby of one channel, then the unsupported output format
  task automatic t_standby;
    logic [7:0] d;
    wr(4'h6, 8'h01);
    repeat (4) @(posedge clk_i);
    rd(4'h7, d);
    `CHK("status", 8'h04, d & 8'hf5)
    meas(13'h1000, 13'h0000, 13'h0400, 13'h0000, 13'h0004);
    wr(4'h6, 8'h00);
    wr(4'h0, 8'h07);
    meas(13'h1000, 13'h0000, 13'h0400, 13'h0000, 13'h0004);
    wr(4'h0, 8'h03);
    repeat (4112) @(posedge clk_i);
    meas(13'h1000, 13'h0800, 13'h0400, 13'h0004, 13'h0004);
  endtask
  // writes taken only while the clock enable is high
  task automatic t_ce;
    wr_rd(4'h4, 8'ha5, 8'ha5);
    @(posedge clk_i);
    ce_i <= 1'b0;
    wr(4'h4, 8'h5a);
    @(posedge clk_i);
    ce_i <= 1'b1;
    chk_rd(4'h4, 8'ha5);
  endtask
  // verdict and end of run
  task automatic summarize;
    if (miscompares == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (8) @(posedge clk_i);
    `CHK("pwm_rst", 2'b00, pwm)
    rst_b_i <= 1'b1;
    t_reset();
    t_periods();
    t_standby();
    t_ce();
    summarize();
  end
  // watchdog, well beyond the expected run of about 32k clocks
  initial begin
    #600000;
    miscompares++;
    summarize();
  end
endmodule
`default_nettype wire
